// file: design/oscp_pkg.sv
package oscp_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DEC = 2'b01,
    ST_ACK = 2'b11,
    ST_END = 2'b10
  } oscp_state_t;

  localparam logic [2:0] FC_CPU_SPACE = 3'h7;
  localparam logic [3:0] CP_SPACE_TYPE = 4'h2;
  localparam logic [2:0] CP_ID_DEFAULT = 3'h1;

  // long word index within the interface block
  localparam logic [2:0] L_RESP_CTRL = 3'h0;
  localparam logic [2:0] L_SAVE_REST = 3'h1;
  localparam logic [2:0] L_OPW_CMD = 3'h2;
  localparam logic [2:0] L_COND = 3'h3;
  localparam logic [2:0] L_OPERAND = 3'h4;
  localparam logic [2:0] L_REGSEL = 3'h5;
  localparam logic [2:0] L_INSTADDR = 3'h6;
  localparam logic [2:0] L_OPADDR = 3'h7;
  localparam int CTRL_ABORT_BIT = 0;

  // {ack1_n, ack0_n}
  localparam logic [1:0] ACK_32 = 2'b00;
  localparam logic [1:0] ACK_16 = 2'b01;
  localparam logic [1:0] ACK_8 = 2'b10;
  localparam logic [1:0] ACK_NONE = 2'b11;

  // arbitrary response and save format codes
  localparam logic [15:0] RESP_BUSY = 16'h8100;
  localparam logic [15:0] RESP_DONE = 16'h0800;
  localparam logic [15:0] SAVE_BUSY = 16'h0100;
  localparam logic [15:0] SAVE_IDLE = 16'h0000;

  localparam logic [15:0] RST_16 = 16'h0000;
  localparam logic [31:0] RST_32 = 32'h0000_0000;

  localparam int CLK_NS = 8;
  localparam int OP_TIME_NS = 400;
  localparam int OP_CYCLES = (OP_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_W = 60;
endpackage

// file: design/oscp_host.sv
`timescale 1ns/1ps
module oscp_host #(
  parameter int PORT_W = 32,
  parameter logic [2:0] CP_ID = oscp_pkg::CP_ID_DEFAULT,
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic as_n,
  input wire logic ds_n,
  input wire logic rw,
  input wire logic [1:0] siz,
  input wire logic [2:0] fc,
  input wire logic [19:0] addr,
  input wire logic [31:0] data_i,
  output logic [31:0] data_o,
  output logic data_oe_n,
  output logic [1:0] port_size_ack_n,
  output logic port_size_ack_oe_n,
  output logic cp_busy,
  output logic [15:0] cp_command,
  output logic [31:0] cp_operand
);
  localparam logic [1:0] ACK_CODE = (PORT_W == 32) ? oscp_pkg::ACK_32 :
    (PORT_W == 16) ? oscp_pkg::ACK_16 : oscp_pkg::ACK_8;

  logic [oscp_pkg::SYNC_W-1:0] s1_r, s2_r, s3_r, f_r;
  oscp_pkg::oscp_state_t state_r;
  logic [15:0] control_r, restore_r, opword_r, command_r, condition_r;
  logic [15:0] regsel_r;
  logic [31:0] operand_r, instaddr_r, opaddr_r;
  logic busy_r;
  logic [CNT_W-1:0] cnt_r;
  logic [31:0] data_r;
  logic oe_r, ack_oe_r;

  logic as_f, ds_f, rw_f;
  logic [1:0] siz_f;
  logic [2:0] fc_f;
  logic [19:0] addr_f;
  logic [31:0] din_f;
  logic sel, go, rd, wr, stall, start, abort;
  logic [2:0] lw;
  logic [1:0] ba;
  logic [3:0] be;
  logic [31:0] view, wd, merged;
  logic [15:0] resp_word, save_word;

  // three stages; a bit moves on once stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_r <= {oscp_pkg::SYNC_W{1'b1}};
      s2_r <= {oscp_pkg::SYNC_W{1'b1}};
      s3_r <= {oscp_pkg::SYNC_W{1'b1}};
      f_r <= {oscp_pkg::SYNC_W{1'b1}};
    end else begin
      s1_r <= {as_n, ds_n, rw, siz, fc, addr, data_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
      f_r <= (s3_r & ~(s2_r ^ s3_r)) | (f_r & (s2_r ^ s3_r));
    end
  end

  assign {as_f, ds_f, rw_f, siz_f, fc_f, addr_f, din_f} = f_r;
  assign lw = addr_f[4:2];
  assign ba = addr_f[1:0];
  // cpu-space cycle with our id on the address lines
  assign sel = (fc_f == oscp_pkg::FC_CPU_SPACE) &&
    (addr_f[19:16] == oscp_pkg::CP_SPACE_TYPE) &&
    (addr_f[15:13] == CP_ID);
  assign go = !as_f && !ds_f && sel;
  assign rd = rw_f;
  assign wr = !rw_f;

  // lanes the processor uses for this width, size and offset
  function automatic logic [3:0] lane_en(input logic [1:0] a,
                                         input logic [1:0] sz);
    int n;
    int lim;
    logic [3:0] e;
    n = (sz == 2'b00) ? 4 : int'(sz);
    if (PORT_W == 32) lim = 4;
    else if (PORT_W == 16) lim = a[1] ? 4 : 2;
    else lim = int'(a) + 1;
    for (int i = 0; i < 4; i++) begin
      e[i] = (i >= int'(a)) && (i < int'(a) + n) && (i < lim);
    end
    return e;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] en);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (en[i]) r[31-8*i -: 8] = nw[31-8*i -: 8];
    end
    return r;
  endfunction

  assign be = lane_en(ba, siz_f);
  // narrow ports only ever see the top lanes
  assign wd = (PORT_W == 32) ? din_f :
    (PORT_W == 16) ? {2{din_f[31:16]}} : {4{din_f[31:24]}};
  assign resp_word = busy_r ? oscp_pkg::RESP_BUSY : oscp_pkg::RESP_DONE;
  assign save_word = busy_r ? oscp_pkg::SAVE_BUSY : oscp_pkg::SAVE_IDLE;

  always_comb begin
    case (lw)
      oscp_pkg::L_RESP_CTRL: view = {resp_word, 16'h0000};
      oscp_pkg::L_SAVE_REST: view = {save_word, restore_r};
      oscp_pkg::L_OPW_CMD: view = 32'h0000_0000;
      oscp_pkg::L_COND: view = 32'h0000_0000;
      oscp_pkg::L_OPERAND: view = operand_r;
      oscp_pkg::L_REGSEL: view = {regsel_r, 16'h0000};
      oscp_pkg::L_INSTADDR: view = instaddr_r;
      oscp_pkg::L_OPADDR: view = opaddr_r;
      default: view = 32'h0000_0000;
    endcase
  end

  always_comb begin
    case (lw)
      oscp_pkg::L_RESP_CTRL: merged = {16'h0000, control_r};
      oscp_pkg::L_SAVE_REST: merged = {16'h0000, restore_r};
      oscp_pkg::L_OPW_CMD: merged = {opword_r, command_r};
      oscp_pkg::L_COND: merged = {16'h0000, condition_r};
      oscp_pkg::L_OPERAND: merged = operand_r;
      oscp_pkg::L_INSTADDR: merged = instaddr_r;
      oscp_pkg::L_OPADDR: merged = opaddr_r;
      default: merged = 32'h0000_0000;
    endcase
    merged = merge(merged, wd, be);
  end

  // a new instruction waits, unacknowledged, for the current one
  assign stall = wr && busy_r && be[3] &&
    (lw == oscp_pkg::L_OPW_CMD || lw == oscp_pkg::L_COND);
  // writes start on the last byte so narrow ports finish the word first; save reads start on the first byte
  assign start = (state_r == oscp_pkg::ST_DEC) && !stall && ((wr && be[3] &&
    (lw == oscp_pkg::L_OPW_CMD || lw == oscp_pkg::L_COND ||
     lw == oscp_pkg::L_SAVE_REST)) ||
    (rd && lw == oscp_pkg::L_SAVE_REST && ba == 2'b00));
  assign abort = (state_r == oscp_pkg::ST_DEC) && wr && be[3] &&
    (lw == oscp_pkg::L_RESP_CTRL) && wd[oscp_pkg::CTRL_ABORT_BIT];

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= oscp_pkg::ST_IDLE;
    end else begin
      case (state_r)
        oscp_pkg::ST_IDLE: if (go) state_r <= oscp_pkg::ST_DEC;
        oscp_pkg::ST_DEC: begin
          if (!go) state_r <= oscp_pkg::ST_IDLE;
          else if (!stall) state_r <= oscp_pkg::ST_ACK;
        end
        oscp_pkg::ST_ACK: if (as_f) state_r <= oscp_pkg::ST_END;
        oscp_pkg::ST_END: state_r <= oscp_pkg::ST_IDLE;
        default: state_r <= oscp_pkg::ST_IDLE;
      endcase
    end
  end

  // bus outputs: width answer and fixed lanes each cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      data_r <= 32'h0000_0000;
      oe_r <= 1'b0;
      ack_oe_r <= 1'b0;
    end else if (state_r == oscp_pkg::ST_DEC && go && !stall) begin
      ack_oe_r <= 1'b1;
      oe_r <= rd;
      if (PORT_W == 32) data_r <= view;
      else if (PORT_W == 16)
        data_r <= {ba[1] ? view[15:0] : view[31:16], 16'h0000};
      else data_r <= {view[8*(3-int'(ba)) +: 8], 24'h00_0000};
    end else if (state_r == oscp_pkg::ST_ACK && as_f) begin
      ack_oe_r <= 1'b0;
      oe_r <= 1'b0;
    end
  end

  assign data_o = data_r;
  assign data_oe_n = !oe_r;
  assign port_size_ack_n = ack_oe_r ? ACK_CODE : oscp_pkg::ACK_NONE;
  assign port_size_ack_oe_n = !ack_oe_r;

  // register writes; response, save and select have no write path
  always_ff @(posedge clk) begin
    if (srst) begin
      control_r <= oscp_pkg::RST_16;
      restore_r <= oscp_pkg::RST_16;
      opword_r <= oscp_pkg::RST_16;
      command_r <= oscp_pkg::RST_16;
      condition_r <= oscp_pkg::RST_16;
      operand_r <= oscp_pkg::RST_32;
      instaddr_r <= oscp_pkg::RST_32;
      opaddr_r <= oscp_pkg::RST_32;
    end else if (state_r == oscp_pkg::ST_DEC && go && wr && !stall) begin
      case (lw)
        oscp_pkg::L_RESP_CTRL: control_r <= merged[15:0];
        oscp_pkg::L_SAVE_REST: restore_r <= merged[15:0];
        oscp_pkg::L_OPW_CMD: begin
          opword_r <= merged[31:16];
          command_r <= merged[15:0];
        end
        oscp_pkg::L_COND: condition_r <= merged[15:0];
        oscp_pkg::L_OPERAND: operand_r <= merged;
        oscp_pkg::L_INSTADDR: instaddr_r <= merged;
        oscp_pkg::L_OPADDR: opaddr_r <= merged;
        default: operand_r <= operand_r;
      endcase
    end
  end

  // no bus request logic: a non-master port, same protocol either way
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
      regsel_r <= oscp_pkg::RST_16;
    end else if (abort) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
    // a start on the last busy cycle wins over the end of the old one
    end else if (start && (!busy_r || cnt_r == '0)) begin
      busy_r <= 1'b1;
      cnt_r <= CNT_W'(oscp_pkg::OP_CYCLES - 1);
      regsel_r <= {13'h0000, merged[2:0]};
    end else if (busy_r) begin
      if (cnt_r == '0) busy_r <= 1'b0;
      else cnt_r <= cnt_r - 1'b1;
    end
  end

  assign cp_busy = busy_r;
  assign cp_command = command_r;
  assign cp_operand = operand_r;

  ack_width_a: assert property (@(posedge clk) disable iff (srst)
    !port_size_ack_oe_n |-> state_r == oscp_pkg::ST_ACK &&
      port_size_ack_n == ACK_CODE)
    else $error("width answer does not match port width");
  lane_fixed_a: assert property (@(posedge clk) disable iff (srst)
    (!data_oe_n && PORT_W == 16) |-> data_o[15:0] == 16'h0000)
    else $error("16-bit port drove low lanes");
  ack_hold_a: assert property (@(posedge clk) disable iff (srst)
    (state_r == oscp_pkg::ST_ACK && !as_f) |=> !port_size_ack_oe_n)
    else $error("answer dropped before strobe release");
  write_quiet_a: assert property (@(posedge clk) disable iff (srst)
    (state_r == oscp_pkg::ST_DEC && go && wr) |=> data_oe_n)
    else $error("data driven on a write cycle");
  busy_stall_a: assert property (@(posedge clk) disable iff (srst)
    (state_r == oscp_pkg::ST_DEC && go && stall) |=> port_size_ack_oe_n)
    else $error("new instruction taken while busy");
  busy_len_a: assert property (@(posedge clk) disable iff (srst)
    (start && !busy_r && !abort) |=> busy_r[*3] ##0
      cnt_r == CNT_W'(oscp_pkg::OP_CYCLES - 3))
    else $error("operation length wrong");
  save_start_a: assert property (@(posedge clk) disable iff (srst)
    (state_r == oscp_pkg::ST_DEC && go && rd && !abort &&
     lw == oscp_pkg::L_SAVE_REST && ba == 2'b00) |=> busy_r)
    else $error("save read did not start a save");
  regsel_ro_a: assert property (@(posedge clk) disable iff (srst)
    (state_r == oscp_pkg::ST_DEC && wr && lw == oscp_pkg::L_REGSEL)
      |=> $stable(regsel_r))
    else $error("register select written by the bus");
  operand_wr_a: assert property (@(posedge clk) disable iff (srst)
    (state_r == oscp_pkg::ST_DEC && go && wr && PORT_W == 32 &&
     lw == oscp_pkg::L_OPERAND && siz_f == 2'b00 && ba == 2'b00)
      |=> operand_r == $past(din_f))
    else $error("operand long write lost");
  resp_busy_a: assert property (@(posedge clk) disable iff (srst)
    (state_r == oscp_pkg::ST_DEC && go && rd && PORT_W == 32 && busy_r &&
     !abort && lw == oscp_pkg::L_RESP_CTRL)
      |=> data_o[31:16] == oscp_pkg::RESP_BUSY)
    else $error("busy not reported in response");
  lane_byte_a: assert property (@(posedge clk) disable iff (srst)
    (!data_oe_n && PORT_W == 8) |-> data_o[23:0] == 24'h00_0000)
    else $error("8-bit port drove low lanes");
  idle_quiet_a: assert property (@(posedge clk) disable iff (srst)
    state_r == oscp_pkg::ST_IDLE |-> port_size_ack_oe_n && data_oe_n)
    else $error("bus driven while idle");
  ack_release_a: assert property (@(posedge clk) disable iff (srst)
    (state_r == oscp_pkg::ST_ACK && as_f) |=> port_size_ack_oe_n && data_oe_n)
    else $error("answer kept after strobe release");
  abort_clear_a: assert property (@(posedge clk) disable iff (srst)
    abort |=> !busy_r && cnt_r == '0)
    else $error("abort did not stop the operation");
  busy_done_a: assert property (@(posedge clk) disable iff (srst)
    (busy_r && cnt_r == '0 && !start && !abort) |=> !busy_r)
    else $error("operation overran its time");
  restore_go_a: assert property (@(posedge clk) disable iff (srst)
    (state_r == oscp_pkg::ST_DEC && go && wr && !stall && be[3] &&
     lw == oscp_pkg::L_SAVE_REST) |=> busy_r)
    else $error("restore write did not start a restore");
  wo_read_a: assert property (@(posedge clk) disable iff (srst)
    (state_r == oscp_pkg::ST_DEC && go && rd &&
     lw == oscp_pkg::L_OPW_CMD) |=> data_o == 32'h0000_0000)
    else $error("write-only word read back nonzero");

  read_c: cover property (@(posedge clk) disable iff (srst)
    state_r == oscp_pkg::ST_ACK && !data_oe_n);
  stall_c: cover property (@(posedge clk) disable iff (srst)
    state_r == oscp_pkg::ST_DEC && stall ##1 state_r == oscp_pkg::ST_ACK);
  save_c: cover property (@(posedge clk) disable iff (srst)
    start && rd);
  abort_c: cover property (@(posedge clk) disable iff (srst)
    abort ##1 !busy_r);
endmodule

// file: tb/oscp_cpu.sv
`timescale 1ns/1ps
module oscp_cpu (
  input wire logic clk,
  input wire logic [31:0] data_o,
  input wire logic data_oe_n,
  input wire logic [1:0] port_size_ack_n,
  input wire logic port_size_ack_oe_n,
  output logic as_n,
  output logic ds_n,
  output logic rw,
  output logic [1:0] siz,
  output logic [2:0] fc,
  output logic [19:0] addr,
  output logic [31:0] data_i
);
  logic [2:0] fc_use = oscp_pkg::FC_CPU_SPACE;
  logic [2:0] id_use = oscp_pkg::CP_ID_DEFAULT;
  initial begin
    as_n = 1'b1;
    ds_n = 1'b1;
    rw = 1'b1;
    siz = 2'h0;
    fc = 3'h0;
    addr = 20'h0_0000;
    data_i = 32'h0000_0000;
  end
  // whole operand sequenced here, no caller help
  task automatic xfer(input logic rd, input logic [4:0] a0,
      input logic [31:0] wd, output logic [31:0] rdd, output int ncyc,
      output logic [1:0] ack1, output int lat);
    logic [31:0] d;
    int n, pb, k, tk, t, ai;
    ai = a0;
    n = 4;
    ncyc = 0;
    lat = 0;
    ack1 = oscp_pkg::ACK_NONE;
    rdd = 32'h0000_0000;
    while (n > 0) begin
      @(posedge clk);
      d = ~data_i;
      // top lanes for narrow ports, address lanes for full width
      for (k = 0; k < n; k++)
        d[31-8*k -: 8] = wd[31-8*(4-n+k) -: 8];
      for (k = 0; k < n && k < 4 - ai % 4; k++)
        d[31-8*(ai%4+k) -: 8] = wd[31-8*(4-n+k) -: 8];
      as_n <= 1'b0;
      ds_n <= 1'b0;
      rw <= rd;
      siz <= 2'(n);
      fc <= fc_use;
      addr <= {4'h2, id_use, 8'h00, 5'(ai)};
      data_i <= rd ? ~data_i : d;
      t = 0;
      do begin
        @(posedge clk);
        t++;
      end while (port_size_ack_oe_n !== 1'b0 && t < 200);
      lat += t;
      if (port_size_ack_oe_n !== 1'b0) begin
        as_n <= 1'b1;
        ds_n <= 1'b1;
        repeat (4) @(posedge clk);
        ncyc = -1;
        return;
      end
      case (port_size_ack_n)
        oscp_pkg::ACK_32: pb = 4;
        oscp_pkg::ACK_16: pb = 2;
        default: pb = 1;
      endcase
      if (ncyc == 0)
        ack1 = port_size_ack_n;
      ncyc++;
      tk = pb - ai % pb;
      if (tk > n)
        tk = n;
      for (k = 0; k < tk && rd; k++)
        rdd[31-8*(4-n+k) -: 8] = data_o[31-8*((ai+k)%pb) -: 8];
      as_n <= 1'b1;
      ds_n <= 1'b1;
      data_i <= ~data_i;
      t = 0;
      while (port_size_ack_oe_n !== 1'b1 && t < 50) begin
        @(posedge clk);
        t++;
      end
      @(posedge clk);
      n -= tk;
      ai += tk;
    end
  endtask
endmodule

// file: tb/operand_sizing_coproc_port_test.sv
`timescale 1ns/1ps
module operand_sizing_coproc_port_test;
  logic clk;
  logic srst;
  int fails;
  int cmp_count;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  for (genvar w = 0; w < 3; w++) begin : g
    logic as_n, ds_n, rw, data_oe_n, ack_oe_n, cp_busy;
    logic [1:0] siz, ack_n;
    logic [2:0] fc;
    logic [19:0] addr;
    logic [31:0] data_o, data_i, cp_operand;
    logic [15:0] cp_command;
    oscp_host #(.PORT_W(32 >> w)) dut (.clk(clk), .srst(srst),
      .as_n(as_n), .ds_n(ds_n), .rw(rw), .siz(siz), .fc(fc), .addr(addr),
      .data_i(data_i), .data_o(data_o), .data_oe_n(data_oe_n),
      .port_size_ack_n(ack_n), .port_size_ack_oe_n(ack_oe_n),
      .cp_busy(cp_busy), .cp_command(cp_command), .cp_operand(cp_operand));
    oscp_cpu cpu (.clk(clk), .data_o(data_o), .data_oe_n(data_oe_n),
      .port_size_ack_n(ack_n), .port_size_ack_oe_n(ack_oe_n), .as_n(as_n),
      .ds_n(ds_n), .rw(rw), .siz(siz), .fc(fc), .addr(addr),
      .data_i(data_i));
  end
  task automatic tally_and_finish();
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk_v(input string nm, input logic [31:0] e,
      input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic chk_n(input string nm, input int e, input int s);
    cmp_count++;
    if (s != e) begin
      fails++;
      $display("[FAIL] %s exp %0d got %0d", nm, e, s);
    end
  endtask
  task automatic bus(input int w, input logic rd, input logic [4:0] a,
      input logic [31:0] wd, output logic [31:0] r, output int n,
      output logic [1:0] ak, output int lat);
    case (w)
      0: g[0].cpu.xfer(rd, a, wd, r, n, ak, lat);
      1: g[1].cpu.xfer(rd, a, wd, r, n, ak, lat);
      default: g[2].cpu.xfer(rd, a, wd, r, n, ak, lat);
    endcase
  endtask
  task automatic sizing_rw(input int w);
    logic [31:0] r;
    logic [1:0] ak;
    logic [1:0] ake;
    int n, lat;
    ake = w == 0 ? oscp_pkg::ACK_32 : w == 1 ? oscp_pkg::ACK_16 : oscp_pkg::ACK_8;
    bus(w, 1'b1, 5'h10, 32'h0000_0000, r, n, ak, lat);
    chk_v("operand reset", oscp_pkg::RST_32, r);
    chk_v("ack code", 32'(ake), 32'(ak));
    bus(w, 1'b0, 5'h10, 32'h1234_5678, r, n, ak, lat);
    chk_n("write cycles", 1 << w, n);
    bus(w, 1'b1, 5'h10, 32'h0000_0000, r, n, ak, lat);
    chk_v("operand read", 32'h1234_5678, r);
    chk_n("read cycles", 1 << w, n);
    bus(w, 1'b1, 5'h11, 32'h0000_0000, r, n, ak, lat);
    chk_v("misaligned read", 32'h3456_7800, r);
    chk_n("misaligned cycles", w + 2, n);
  endtask
  task automatic busy_cmd();
    logic [31:0] r;
    logic [1:0] ak;
    int n, lat, k;
    bus(0, 1'b0, 5'h08, 32'hABCD_0042, r, n, ak, lat);
    chk_v("busy", 32'h0000_0001, 32'(g[0].cp_busy));
    chk_v("command", 32'h0000_0042, 32'(g[0].cp_command));
    bus(0, 1'b1, 5'h00, 32'h0000_0000, r, n, ak, lat);
    chk_v("response busy", {oscp_pkg::RESP_BUSY, 16'h0000}, r);
    bus(0, 1'b0, 5'h08, 32'h0000_0055, r, n, ak, lat);
    chk_n("held while busy", 1, int'(lat > 15));
    chk_v("second command", 32'h0000_0055, 32'(g[0].cp_command));
    k = 0;
    while (g[0].cp_busy === 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    // second op began a few edges before the count started
    chk_n("busy span", 1, int'(k >= 40 && k <= oscp_pkg::OP_CYCLES));
    bus(0, 1'b1, 5'h00, 32'h0000_0000, r, n, ak, lat);
    chk_v("response done", {oscp_pkg::RESP_DONE, 16'h0000}, r);
    bus(0, 1'b1, 5'h0C, 32'h0000_0000, r, n, ak, lat);
    chk_v("condition read", 32'h0000_0000, r);
    bus(0, 1'b1, 5'h08, 32'h0000_0000, r, n, ak, lat);
    chk_v("opword read", 32'h0000_0000, r);
    // select holds bits 2:0 of the last command word, here 5
    bus(0, 1'b1, 5'h14, 32'h0000_0000, r, n, ak, lat);
    chk_v("regsel read", 32'h0005_0000, r);
    bus(0, 1'b0, 5'h14, 32'hFFFF_FFFF, r, n, ak, lat);
    bus(0, 1'b1, 5'h14, 32'h0000_0000, r, n, ak, lat);
    chk_v("regsel read-only", 32'h0005_0000, r);
  endtask
  task automatic save_restore();
    logic [31:0] r;
    logic [1:0] ak;
    int n, lat;
    bus(0, 1'b0, 5'h04, 32'hFFFF_BEEF, r, n, ak, lat);
    chk_v("restore starts", 32'h0000_0001, 32'(g[0].cp_busy));
    bus(0, 1'b0, 5'h00, 32'h0000_0001, r, n, ak, lat);
    chk_v("abort", 32'h0000_0000, 32'(g[0].cp_busy));
    bus(0, 1'b1, 5'h04, 32'h0000_0000, r, n, ak, lat);
    chk_v("save word", {oscp_pkg::SAVE_IDLE, 16'hBEEF}, r);
    chk_v("save starts", 32'h0000_0001, 32'(g[0].cp_busy));
    bus(0, 1'b0, 5'h00, 32'h0000_0001, r, n, ak, lat);
    chk_v("abort again", 32'h0000_0000, 32'(g[0].cp_busy));
  endtask
  task automatic unselected();
    logic [31:0] r;
    logic [1:0] ak;
    int n, lat;
    g[0].cpu.fc_use = 3'h5;
    bus(0, 1'b1, 5'h10, 32'h0000_0000, r, n, ak, lat);
    chk_n("wrong space", -1, n);
    g[0].cpu.fc_use = oscp_pkg::FC_CPU_SPACE;
    g[0].cpu.id_use = 3'h2;
    bus(0, 1'b1, 5'h10, 32'h0000_0000, r, n, ak, lat);
    chk_n("wrong id", -1, n);
    g[0].cpu.id_use = oscp_pkg::CP_ID_DEFAULT;
    bus(0, 1'b1, 5'h10, 32'h0000_0000, r, n, ak, lat);
    chk_v("still alive", 32'h1234_5678, r);
  endtask
  // generous span: bounded waits inside the model dominate
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
  initial begin
    srst = 1'b1;
    fails = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int w = 0; w < 3; w++)
      sizing_rw(w);
    busy_cmd();
    save_restore();
    unselected();
    tally_and_finish();
  end
endmodule
